// [pkg/bcu_pkg.sv]
`default_nettype none
package bcu_pkg;
   localparam int unsigned BCU_DATA_W = 32;
   localparam int unsigned BCU_ADDR_W = 8;
   localparam int unsigned BCU_PC_W = 16;
   localparam int unsigned BCU_OFF_W = 8;
   localparam int unsigned BCU_FLAG_W = 4;

   // Register byte addresses.
   localparam logic [BCU_ADDR_W-1:0] BCU_ADDR_INSTR = 8'h00;
   localparam logic [BCU_ADDR_W-1:0] BCU_ADDR_PC = 8'h04;
   localparam logic [BCU_ADDR_W-1:0] BCU_ADDR_FLAGS = 8'h08;
   localparam logic [BCU_ADDR_W-1:0] BCU_ADDR_TARGET = 8'h0C;
   localparam logic [BCU_ADDR_W-1:0] BCU_ADDR_STATUS = 8'h10;

   // Instruction field positions.
   localparam int unsigned BCU_OPC_LSB = 8;
   localparam int unsigned BCU_OPC_MSB = 15;
   localparam int unsigned BCU_OFF_MSB = 7;

   // Condition flag positions in the flags register.
   localparam int unsigned BCU_FLAG_C = 0;
   localparam int unsigned BCU_FLAG_V = 1;
   localparam int unsigned BCU_FLAG_Z = 2;
   localparam int unsigned BCU_FLAG_N = 3;

   // Status register bit positions.
   localparam int unsigned BCU_STAT_TAKEN = 0;
   localparam int unsigned BCU_STAT_KNOWN = 1;
   localparam int unsigned BCU_STAT_DONE = 2;

   // Reset values.
   localparam logic [BCU_DATA_W-1:0] BCU_RST_WORD = 32'h0000_0000;
   localparam logic [BCU_FLAG_W-1:0] BCU_RST_FLAGS = 4'h0;

   // Opcode byte values, instruction bits 15 to 8.
   localparam logic [7:0] BCU_OP_BRANCH_ALWAYS = 8'h01;
   localparam logic [7:0] BCU_OP_BRANCH_IF_UNEQUAL = 8'h02;
   localparam logic [7:0] BCU_OP_BRANCH_IF_EQUAL = 8'h03;
   localparam logic [7:0] BCU_OP_BRANCH_SIGNED_NOT_LESS = 8'h04;
   localparam logic [7:0] BCU_OP_BRANCH_SIGNED_LESS = 8'h05;
   localparam logic [7:0] BCU_OP_BRANCH_SIGNED_GREATER = 8'h06;
   localparam logic [7:0] BCU_OP_BRANCH_SIGNED_AT_MOST = 8'h07;
   localparam logic [7:0] BCU_OP_BRANCH_IF_POSITIVE = 8'h80;
   localparam logic [7:0] BCU_OP_BRANCH_IF_NEGATIVE = 8'h81;
   localparam logic [7:0] BCU_OP_BRANCH_OVERFLOW_ZERO = 8'h84;
   localparam logic [7:0] BCU_OP_BRANCH_OVERFLOW_ONE = 8'h85;
   localparam logic [7:0] BCU_OP_BRANCH_CARRY_ZERO = 8'h86;
   localparam logic [7:0] BCU_OP_BRANCH_CARRY_ONE = 8'h87;
endpackage
`default_nettype wire

// [core/bcu_cond.sv]
`timescale 1ns/1ns
`default_nettype none
module bcu_cond
(
   input wire logic [7:0] opcode,
   input wire logic [bcu_pkg::BCU_FLAG_W-1:0] flags,
   output logic known,
   output logic taken
);
   import bcu_pkg::*;

   logic n;
   logic z;
   logic v;
   logic c;

   assign n = flags[BCU_FLAG_N];
   assign z = flags[BCU_FLAG_Z];
   assign v = flags[BCU_FLAG_V];
   assign c = flags[BCU_FLAG_C];

   // Decodes the opcode byte and tests the flags it names.
   always_comb
   begin
      known = 1'b1;
      taken = 1'b0;
      case (opcode)
         BCU_OP_BRANCH_ALWAYS: taken = 1'b1;
         BCU_OP_BRANCH_IF_EQUAL: taken = z;
         BCU_OP_BRANCH_IF_UNEQUAL: taken = ~z;
         BCU_OP_BRANCH_IF_NEGATIVE: taken = n;
         BCU_OP_BRANCH_IF_POSITIVE: taken = ~n;
         BCU_OP_BRANCH_CARRY_ONE: taken = c;
         BCU_OP_BRANCH_CARRY_ZERO: taken = ~c;
         BCU_OP_BRANCH_OVERFLOW_ONE: taken = v;
         BCU_OP_BRANCH_OVERFLOW_ZERO: taken = ~v;
         BCU_OP_BRANCH_SIGNED_LESS: taken = n ^ v;
         BCU_OP_BRANCH_SIGNED_NOT_LESS: taken = ~(n ^ v);
         BCU_OP_BRANCH_SIGNED_AT_MOST: taken = z | (n ^ v);
         BCU_OP_BRANCH_SIGNED_GREATER: taken = ~z & ~(n ^ v);
         default: known = 1'b0;
      endcase
   end
endmodule // bcu_cond
`default_nettype wire

// [core/bcu_top.sv]
`timescale 1ns/1ns
`default_nettype none
//
// Contract
// - Target adds offset times two to PC.
// - Base is address after the branch.
// - Offset is signed, bit 7 sign.
// - Reach 200 octal back, 177 forward.
// - Branches never change condition flags.
// - Unconditional branch always loads target.
// - Equal branch taken when Z set.
// - Unequal branch taken when Z clear.
// - Negative branch taken when N set.
// - Positive branch taken when N clear.
// - Carry-one branch taken when C set.
// - Carry-zero branch taken when C clear.
// - Overflow-one branch taken when V set.
// - Overflow-zero branch taken when V clear.
// - Signed less taken when N xor V.
// - Signed not-less taken when N equals V.
// - Signed at-most taken when Z or N^V.
// - Signed greater taken when !Z and N==V.
module bcu_top
#(
   parameter int unsigned PC_W = bcu_pkg::BCU_PC_W
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [bcu_pkg::BCU_ADDR_W-1:0] paddr,
   input wire logic [bcu_pkg::BCU_DATA_W-1:0] pwdata,
   output logic [bcu_pkg::BCU_DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic pc_load,
   output logic [PC_W-1:0] next_pc,
   output logic [bcu_pkg::BCU_FLAG_W-1:0] flags_out
);
   import bcu_pkg::*;

   if (PC_W < BCU_OFF_W + 1 || PC_W > BCU_DATA_W)
   begin : g_bad_width
      $error("PC_W must lie between 9 and 32.");
   end

   logic setup;
   logic access;
   logic wr_instr;
   logic wr_pc;
   logic wr_flags;
   logic mapped;
   logic [7:0] opcode;
   logic [BCU_OFF_W-1:0] offset;
   logic [PC_W-1:0] disp;
   logic [PC_W-1:0] target;
   logic cond_known;
   logic cond_taken;

   logic [PC_W-1:0] pc_q;
   logic [PC_W-1:0] pc_d;
   logic [BCU_FLAG_W-1:0] flags_q;
   logic [BCU_FLAG_W-1:0] flags_d;
   logic [15:0] instr_q;
   logic [15:0] instr_d;
   logic [PC_W-1:0] next_pc_q;
   logic [PC_W-1:0] next_pc_d;
   logic taken_q;
   logic taken_d;
   logic known_q;
   logic known_d;
   logic done_q;
   logic done_d;
   logic load_q;
   logic load_d;
   logic [BCU_DATA_W-1:0] prdata_q;
   logic [BCU_DATA_W-1:0] prdata_d;
   logic slverr_q;
   logic slverr_d;

   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign wr_instr = access & pwrite & (paddr == BCU_ADDR_INSTR);
   assign wr_pc = access & pwrite & (paddr == BCU_ADDR_PC);
   assign wr_flags = access & pwrite & (paddr == BCU_ADDR_FLAGS);

   // The opcode and offset come straight from the written instruction word.
   assign opcode = pwdata[BCU_OPC_MSB:BCU_OPC_LSB];
   assign offset = pwdata[BCU_OFF_MSB:0];

   // Sign extension of the word offset, then a shift to a byte count.
   assign disp = {{(PC_W-BCU_OFF_W-1){offset[BCU_OFF_W-1]}}, offset, 1'b0};
   // The base is the incremented PC held for the word after the branch.
   assign target = pc_q + disp;

   bcu_cond u_cond
   (
      .opcode(opcode),
      .flags(flags_q),
      .known(cond_known),
      .taken(cond_taken)
   );

   // Branch evaluation, launched by a write of the instruction register.
   always_comb
   begin
      pc_d = pc_q;
      instr_d = instr_q;
      next_pc_d = next_pc_q;
      taken_d = taken_q;
      known_d = known_q;
      done_d = done_q;
      load_d = 1'b0;
      if (wr_pc)
      begin
         pc_d = pwdata[PC_W-1:0];
      end
      if (wr_instr)
      begin
         instr_d = pwdata[15:0];
         known_d = cond_known;
         taken_d = cond_known & cond_taken;
         done_d = 1'b1;
         load_d = cond_known & cond_taken;
         if (cond_known & cond_taken)
         begin
            next_pc_d = target;
         end
         else
         begin
            next_pc_d = pc_q;
         end
      end
   end

   // Only software writes the flags; a branch never touches them.
   always_comb
   begin
      flags_d = flags_q;
      if (wr_flags)
      begin
         flags_d = pwdata[BCU_FLAG_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pc_q <= '0;
         flags_q <= BCU_RST_FLAGS;
         instr_q <= '0;
         next_pc_q <= '0;
         taken_q <= 1'b0;
         known_q <= 1'b0;
         done_q <= 1'b0;
         load_q <= 1'b0;
      end
      else
      begin
         pc_q <= pc_d;
         flags_q <= flags_d;
         instr_q <= instr_d;
         next_pc_q <= next_pc_d;
         taken_q <= taken_d;
         known_q <= known_d;
         done_q <= done_d;
         load_q <= load_d;
      end
   end

   // Read data and error are prepared in the setup phase.
   always_comb
   begin
      mapped = 1'b1;
      prdata_d = prdata_q;
      slverr_d = slverr_q;
      if (setup)
      begin
         prdata_d = BCU_RST_WORD;
         if (paddr == BCU_ADDR_INSTR)
         begin
            prdata_d[15:0] = instr_q;
         end
         else if (paddr == BCU_ADDR_PC)
         begin
            prdata_d[PC_W-1:0] = pc_q;
         end
         else if (paddr == BCU_ADDR_FLAGS)
         begin
            prdata_d[BCU_FLAG_W-1:0] = flags_q;
         end
         else if (paddr == BCU_ADDR_TARGET)
         begin
            prdata_d[PC_W-1:0] = next_pc_q;
         end
         else if (paddr == BCU_ADDR_STATUS)
         begin
            prdata_d[BCU_STAT_TAKEN] = taken_q;
            prdata_d[BCU_STAT_KNOWN] = known_q;
            prdata_d[BCU_STAT_DONE] = done_q;
         end
         else
         begin
            mapped = 1'b0;
         end
         if (!pwrite)
         begin
            slverr_d = ~mapped;
         end
         else
         begin
            slverr_d = ~mapped;
            prdata_d = BCU_RST_WORD;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_q <= BCU_RST_WORD;
         slverr_q <= 1'b0;
      end
      else
      begin
         prdata_q <= prdata_d;
         slverr_q <= slverr_d;
      end
   end

   assign pready = 1'b1;
   assign prdata = prdata_q;
   assign pslverr = slverr_q & access;
   assign pc_load = load_q;
   assign next_pc = next_pc_q;
   assign flags_out = flags_q;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_target_math: assert property (wr_instr && cond_known && cond_taken |=>
      next_pc_q == PC_W'($past(pc_q) + PC_W'(signed'($past(pwdata[7:0]))) * 2))
      else $error("Taken branch target is not base plus twice the offset.");
   a_base_pc: assert property (wr_instr ##1 !taken_q && known_q |-> next_pc_q == pc_q)
      else $error("Untaken branch did not keep the incremented PC.");
   a_backward_sign: assert property (wr_instr && cond_taken && cond_known && pwdata[7] |=>
      (next_pc_q - $past(pc_q)) >= PC_W'(2 ** PC_W - 256))
      else $error("Negative offset did not branch backward.");
   a_forward_reach: assert property (wr_instr && cond_taken && cond_known && !pwdata[7] |=>
      (next_pc_q - $past(pc_q)) <= PC_W'(254))
      else $error("Forward branch reach exceeds 177 octal words.");
   a_flags_stable: assert property (!wr_flags |=> flags_q == $past(flags_q))
      else $error("Condition flags changed without a flag write.");
   a_always_taken: assert property (wr_instr && pwdata[15:8] == BCU_OP_BRANCH_ALWAYS |=> taken_q && pc_load)
      else $error("Unconditional branch was not taken.");
   a_equal_test: assert property (wr_instr && pwdata[15:8] == BCU_OP_BRANCH_IF_EQUAL
      |=> taken_q == $past(flags_q[BCU_FLAG_Z]))
      else $error("Equal branch does not follow Z.");
   a_signed_less: assert property (wr_instr && pwdata[15:8] == BCU_OP_BRANCH_SIGNED_LESS
      |=> taken_q == ($past(flags_q[BCU_FLAG_N]) ^ $past(flags_q[BCU_FLAG_V])))
      else $error("Signed less branch does not follow N xor V.");
   a_signed_greater: assert property (wr_instr && pwdata[15:8] == BCU_OP_BRANCH_SIGNED_GREATER
      |=> taken_q == (!$past(flags_q[BCU_FLAG_Z]) && !($past(flags_q[BCU_FLAG_N]) ^ $past(flags_q[BCU_FLAG_V]))))
      else $error("Signed greater branch does not follow Z and N xor V.");
   a_load_pulse: assert property (pc_load |=> !pc_load || $past(wr_instr))
      else $error("PC load held without a new instruction.");
   a_unequal_test: assert property (wr_instr && pwdata[15:8] == BCU_OP_BRANCH_IF_UNEQUAL
      |=> taken_q == !$past(flags_q[BCU_FLAG_Z]))
      else $error("Unequal branch does not follow Z clear.");
   a_negative_test: assert property (wr_instr && pwdata[15:8] == BCU_OP_BRANCH_IF_NEGATIVE
      |=> taken_q == $past(flags_q[BCU_FLAG_N]))
      else $error("Negative branch does not follow N.");
   a_positive_test: assert property (wr_instr && pwdata[15:8] == BCU_OP_BRANCH_IF_POSITIVE
      |=> taken_q == !$past(flags_q[BCU_FLAG_N]))
      else $error("Positive branch does not follow N clear.");
   a_carry_one: assert property (wr_instr && pwdata[15:8] == BCU_OP_BRANCH_CARRY_ONE
      |=> taken_q == $past(flags_q[BCU_FLAG_C]))
      else $error("Carry-one branch does not follow C.");
   a_carry_zero: assert property (wr_instr && pwdata[15:8] == BCU_OP_BRANCH_CARRY_ZERO
      |=> taken_q == !$past(flags_q[BCU_FLAG_C]))
      else $error("Carry-zero branch does not follow C clear.");
   a_overflow_one: assert property (wr_instr && pwdata[15:8] == BCU_OP_BRANCH_OVERFLOW_ONE
      |=> taken_q == $past(flags_q[BCU_FLAG_V]))
      else $error("Overflow-one branch does not follow V.");
   a_overflow_zero: assert property (wr_instr && pwdata[15:8] == BCU_OP_BRANCH_OVERFLOW_ZERO
      |=> taken_q == !$past(flags_q[BCU_FLAG_V]))
      else $error("Overflow-zero branch does not follow V clear.");
   a_signed_not_less: assert property (wr_instr && pwdata[15:8] == BCU_OP_BRANCH_SIGNED_NOT_LESS
      |=> taken_q == ($past(flags_q[BCU_FLAG_N]) == $past(flags_q[BCU_FLAG_V])))
      else $error("Signed not-less branch does not follow N equal to V.");
   a_signed_at_most: assert property (wr_instr && pwdata[15:8] == BCU_OP_BRANCH_SIGNED_AT_MOST
      |=> taken_q == ($past(flags_q[BCU_FLAG_Z]) || ($past(flags_q[BCU_FLAG_N]) ^ $past(flags_q[BCU_FLAG_V]))))
      else $error("Signed at-most branch does not follow Z or N xor V.");

   c_taken_back: cover property (wr_instr && cond_taken && pwdata[7] ##1 pc_load);
   c_taken_fwd: cover property (wr_instr && cond_taken && !pwdata[7] ##1 pc_load);
   c_untaken: cover property (wr_instr && cond_known && !cond_taken);
   c_unknown_op: cover property (wr_instr && !cond_known);
endmodule // bcu_top
`default_nettype wire

// [tb/bcu_top_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module bcu_top_tb_top;
   import bcu_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic pc_load;
   logic [15:0] next_pc;
   logic [3:0] flags_out;
   int n_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   logic [31:0] seed = 32'd93;
   logic [15:0] last_tg = 16'h0;
   logic [7:0] ops [15] = '{BCU_OP_BRANCH_ALWAYS, BCU_OP_BRANCH_IF_UNEQUAL, BCU_OP_BRANCH_IF_EQUAL,
      BCU_OP_BRANCH_SIGNED_NOT_LESS, BCU_OP_BRANCH_SIGNED_LESS, BCU_OP_BRANCH_SIGNED_GREATER,
      BCU_OP_BRANCH_SIGNED_AT_MOST, BCU_OP_BRANCH_IF_POSITIVE, BCU_OP_BRANCH_IF_NEGATIVE,
      BCU_OP_BRANCH_OVERFLOW_ZERO, BCU_OP_BRANCH_OVERFLOW_ONE, BCU_OP_BRANCH_CARRY_ZERO,
      BCU_OP_BRANCH_CARRY_ONE, 8'h00, 8'hFF};

   bcu_top bcu_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pc_load(pc_load), .next_pc(next_pc), .flags_out(flags_out));

   always #20 pclk = ~pclk;

   // Next value of the repeatable random sequence.
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Expected {recognised, taken} for an opcode and flags {N,Z,V,C}.
   function automatic logic [1:0] exp_kt(input logic [7:0] op, input logic [3:0] f);
      logic n, z, v, c;
      begin
         {n, z, v, c} = f;
         case (op)
            BCU_OP_BRANCH_ALWAYS: return 2'b11;
            BCU_OP_BRANCH_IF_UNEQUAL: return {1'b1, !z};
            BCU_OP_BRANCH_IF_EQUAL: return {1'b1, z};
            BCU_OP_BRANCH_SIGNED_NOT_LESS: return {1'b1, n == v};
            BCU_OP_BRANCH_SIGNED_LESS: return {1'b1, n ^ v};
            BCU_OP_BRANCH_SIGNED_GREATER: return {1'b1, !z && (n == v)};
            BCU_OP_BRANCH_SIGNED_AT_MOST: return {1'b1, z || (n ^ v)};
            BCU_OP_BRANCH_IF_POSITIVE: return {1'b1, !n};
            BCU_OP_BRANCH_IF_NEGATIVE: return {1'b1, n};
            BCU_OP_BRANCH_OVERFLOW_ZERO: return {1'b1, !v};
            BCU_OP_BRANCH_OVERFLOW_ONE: return {1'b1, v};
            BCU_OP_BRANCH_CARRY_ZERO: return {1'b1, !c};
            BCU_OP_BRANCH_CARRY_ONE: return {1'b1, c};
            default: return 2'b00;
         endcase
      end
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer; entered just after a rising edge, returns at the edge that completes it.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err, input logic last);
      begin
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= wr;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         do @(posedge pclk); while (pready !== 1'b1);
         rd = prdata;
         err = pslverr;
         if (last)
         begin
            psel <= 1'b0;
            penable <= 1'b0;
         end
      end
   endtask

   task automatic run(input logic [7:0] op, input logic [3:0] f, input logic [7:0] off, input logic [15:0] pc);
      logic [31:0] rd;
      logic e;
      logic [1:0] kt;
      logic [15:0] tg;
      int pl;
      begin
         kt = exp_kt(op, f);
         tg = kt[0] ? pc + {{7{off[7]}}, off, 1'b0} : pc;
         apb(1'b1, BCU_ADDR_PC, {16'h0, pc}, rd, e, 1'b0);
         apb(1'b1, BCU_ADDR_FLAGS, {28'h0, f}, rd, e, 1'b0);
         apb(1'b1, BCU_ADDR_INSTR, {16'h0, op, off}, rd, e, 1'b1);
         pl = 0;
         repeat (2)
         begin
            @(negedge pclk);
            if (pc_load === 1'b1)
               pl++;
         end
         chk(32'(pl), {31'h0, kt[0]});
         chk({16'h0, next_pc}, {16'h0, tg});
         chk({28'h0, flags_out}, {28'h0, f});
         @(posedge pclk);
         apb(1'b0, BCU_ADDR_TARGET, 32'h0, rd, e, 1'b0);
         chk(rd, {16'h0, tg});
         apb(1'b0, BCU_ADDR_STATUS, 32'h0, rd, e, 1'b0);
         chk(rd, {29'h0, 1'b1, kt});
         apb(1'b0, BCU_ADDR_FLAGS, 32'h0, rd, e, 1'b1);
         chk(rd, {28'h0, f});
         last_tg = tg;
      end
   endtask

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // A hang is cut short well beyond the expected run length.
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         tally_and_finish();
      end
   end

   initial
   begin
      logic [31:0] rd;
      logic e;
      logic [7:0] off;
      logic [15:0] pc;
      logic [31:0] rnd;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 5; i++)
      begin
         apb(1'b0, 8'(4 * i), 32'h0, rd, e, i == 4);
         chk(rd, 32'h0);
      end
      @(posedge pclk);
      for (int o = 0; o < 15; o++)
      begin
         for (int f = 0; f < 16; f++)
         begin
            rnd = xs();
            off = (f == 0) ? 8'h80 : (f == 1) ? 8'h7F : rnd[7:0];
            rnd = xs();
            pc = (f == 0) ? 16'h0000 : (f == 1) ? 16'hFFFE : rnd[15:0];
            run(ops[o], 4'(f), off, pc);
            @(posedge pclk);
         end
      end
      apb(1'b0, 8'h14, 32'h0, rd, e, 1'b0);
      chk({rd[30:0], e}, 32'h1);
      apb(1'b1, 8'h40, xs(), rd, e, 1'b0);
      chk({31'h0, e}, 32'h1);
      apb(1'b1, BCU_ADDR_TARGET, xs(), rd, e, 1'b0);
      chk({31'h0, e}, 32'h0);
      apb(1'b0, BCU_ADDR_TARGET, 32'h0, rd, e, 1'b1);
      chk(rd, {16'h0, last_tg});
      tally_and_finish();
   end
endmodule // bcu_top_tb_top
`default_nettype wire
